/* File: hdl/hpr_map.svh */
/*
 Holds the register numbers, CPU word offsets, field positions and timing counts of the host parallel RAM port.
 Assumes it is included by bare name from the module files.
*/
`ifndef HPR_MAP_SVH
`define HPR_MAP_SVH
// ****************************************
// Register numbers in the index field
// ****************************************
`define HPR_REG_GSR 6'h00
`define HPR_REG_SCR 6'h01
`define HPR_REG_MCR 6'h02
`define HPR_REG_IICR 6'h03
`define HPR_REG_EICR 6'h04
`define HPR_REG_ADR 6'h05
`define HPR_REG_DATA 6'h06
`define HPR_REG_BCR 6'h07
// ****************************************
// CPU side word offsets
// ****************************************
`define HPR_CPU_IDX 4'h0
`define HPR_CPU_GSR 4'h1
`define HPR_CPU_SCR 4'h2
`define HPR_CPU_MCR 4'h3
`define HPR_CPU_IICR 4'h4
`define HPR_CPU_EICR 4'h5
`define HPR_CPU_ADR 4'h6
`define HPR_CPU_DATA 4'h7
`define HPR_CPU_BCR 4'h8
`define HPR_CPU_DTR 4'h9
`define HPR_CPU_BICR 4'hA
`define HPR_CPU_RAM 4'hF
// ****************************************
// Field positions, address step, last word and pulse length
// ****************************************
`define HPR_IDX_REG_MSB 5
`define HPR_SCR_BANKED 0
`define HPR_SCR_BSEL 1
`define HPR_SCR_SWAP 2
`define HPR_SCR_PMODE 3
`define HPR_SCR_POL 4
`define HPR_MCR_STEP 0
`define HPR_MCR_DOWN 1
`define HPR_IRQ_FLAG 0
`define HPR_IRQ_CODE_LSB 1
`define HPR_IRQ_CODE_MSB 7
`define HPR_BCR_HOST_OWNS 0
`define HPR_DTR_TRIG 0
`define HPR_BICR_STAT 0
`define HPR_ADDR_MSB 9
`define HPR_ADDR_STEP 10'h004
`define HPR_LAST_WORD 8'hFF
`define HPR_PULSE_CYCLES 6'h20
`endif

/* File: hdl/hpr_pkg.sv */
/*
 Holds the shared types of the host parallel RAM port.
 Assumes the map header sits in the include path.
*/
package hpr_pkg;
  typedef enum logic [1:0] {HPR_IDLE, HPR_ACT, HPR_WAIT} hpr_st_t;
  typedef logic [31:0] hpr_word_t;
endpackage : hpr_pkg

/* File: hdl/hpr_if.sv */
/*
 Holds the pin interface between the port and its host.
 Assumes both ends share mclk; the host drives the strobes, the port drives read data and the request.
*/
`timescale 1ns/100ps
`default_nettype none
interface hpr_if;
  logic host_select_n;
  logic host_reg_select;
  logic host_write_strobe_n;
  logic host_read_strobe_n;
  logic [31:0] host_wdata;
  logic [31:0] host_rdata;
  logic host_rdata_oe;
  logic host_dma_request;
  logic host_irq;
  modport dev (input host_select_n, host_reg_select, host_write_strobe_n, host_read_strobe_n, host_wdata,
    output host_rdata, host_rdata_oe, host_dma_request, host_irq);
  modport host (output host_select_n, host_reg_select, host_write_strobe_n, host_read_strobe_n, host_wdata,
    input host_rdata, host_rdata_oe, host_dma_request, host_irq);
endinterface : hpr_if
`default_nettype wire

/* File: hdl/hpr_sync2.sv */
/*
 Holds a two flip-flop synchroniser for a bundle of levels.
 Assumes inputs change slowly against mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module hpr_sync2 #(parameter int W = 4, parameter logic [W-1:0] INIT = '1) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= INIT;
      q <= INIT;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule : hpr_sync2
`default_nettype wire

/* File: hdl/hpr_dev.sv */
/*
 Holds the device end: shared RAM, indexed host registers, CPU register port, interrupts and DMA request.
 Assumes a simple one-cycle CPU bus with byte enables and a host joined through hpr_if.
*/
`include "hpr_map.svh"
`timescale 1ns/100ps
`default_nettype none
module hpr_dev import hpr_pkg::*; #(parameter int WORDS = 512) (
  input wire logic mclk,
  input wire logic rst_b,
  hpr_if.dev hp,
  input wire logic cpu_sel,
  input wire logic cpu_wr,
  input wire logic [3:0] cpu_be,
  input wire logic [3:0] cpu_reg,
  input wire logic [9:0] cpu_ram_addr,
  input wire logic [31:0] cpu_wdata,
  input wire logic host_boot,
  output logic [31:0] cpu_rdata,
  output logic cpu_irq,
  output logic cpu_boot_from_ram,
  output logic host_ram_owner
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    hpr_st_t st;
    logic [7:0] idx;
    hpr_word_t gsr, scr, mcr, iicr, eicr, adr, data, bcr, dtr, bicr, rd, cpu_rd;
    logic [5:0] pcnt;
    logic dreq, boot, cirq, oe, dpin;
  } hpr_dev_s_t;
  hpr_dev_s_t s_ff, nxt_s;
  hpr_word_t ram_ff [WORDS];
  logic [3:0] pin_q;
  hpr_sync2 #(.W(4), .INIT(4'hF)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d({hp.host_select_n, hp.host_reg_select, hp.host_write_strobe_n, hp.host_read_strobe_n}),
    .q(pin_q)
  );
  logic cs, rs, wr, rd;
  logic [8:0] h_word, c_word;
  logic [5:0] rnum;
  hpr_word_t hw, ram_hrd, ram_crd;
  always_comb begin
    cs = !pin_q[3];
    rs = pin_q[2];
    wr = cs && !pin_q[1];
    rd = cs && !pin_q[0];
    rnum = s_ff.idx[`HPR_IDX_REG_MSB:0];
    hw = s_ff.scr[`HPR_SCR_SWAP] ? {<<8{hp.host_wdata}} : hp.host_wdata;
    // Banked mode lets the bank bit pick the bank; otherwise the address spans both.
    h_word = s_ff.scr[`HPR_SCR_BANKED] ? {s_ff.scr[`HPR_SCR_BSEL], s_ff.adr[`HPR_ADDR_MSB:2]}
      : {s_ff.adr[`HPR_ADDR_MSB + 1], s_ff.adr[`HPR_ADDR_MSB:2]};
    // The CPU byte address spans one kbyte, so in non-banked mode it reaches the lower bank only.
    c_word = {s_ff.scr[`HPR_SCR_BANKED] & s_ff.scr[`HPR_SCR_BSEL], cpu_ram_addr[`HPR_ADDR_MSB:2]};
    ram_hrd = ram_ff[h_word];
    ram_crd = ram_ff[c_word];
  end
  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_s = s_ff;
    nxt_s.oe = rd;
    case (s_ff.st)
      HPR_IDLE: begin
        if (wr || rd) begin
          nxt_s.st = HPR_ACT;
        end
      end
      HPR_ACT: begin
        nxt_s.st = HPR_WAIT;
        if (rs && wr) begin
          nxt_s.idx = hp.host_wdata[7:0];
        end else if (rs && rd) begin
          nxt_s.rd = s_ff.gsr;
        end else if (rd) begin
          case (rnum)
            `HPR_REG_GSR: nxt_s.rd = s_ff.gsr;
            `HPR_REG_SCR: nxt_s.rd = s_ff.scr;
            `HPR_REG_MCR: nxt_s.rd = s_ff.mcr;
            `HPR_REG_IICR: nxt_s.rd = s_ff.iicr;
            `HPR_REG_EICR: nxt_s.rd = s_ff.eicr;
            `HPR_REG_ADR: nxt_s.rd = s_ff.adr;
            `HPR_REG_DATA: begin
              nxt_s.rd = s_ff.scr[`HPR_SCR_SWAP] ? {<<8{ram_hrd}} : ram_hrd;
              nxt_s.data = ram_hrd;
            end
            `HPR_REG_BCR: nxt_s.rd = s_ff.bcr;
            default: nxt_s.rd = 32'h0000_0000;
          endcase
        end else if (wr) begin
          case (rnum)
            `HPR_REG_GSR: nxt_s.gsr = hp.host_wdata;
            `HPR_REG_SCR: nxt_s.scr = hp.host_wdata;
            `HPR_REG_MCR: nxt_s.mcr = hp.host_wdata;
            `HPR_REG_IICR: nxt_s.iicr = hp.host_wdata;
            `HPR_REG_EICR: nxt_s.eicr[`HPR_IRQ_FLAG] = 1'b0;
            `HPR_REG_ADR: nxt_s.adr = hp.host_wdata;
            `HPR_REG_DATA: nxt_s.data = hw;
            `HPR_REG_BCR: nxt_s.bcr = hp.host_wdata;
            default: nxt_s.gsr = s_ff.gsr;
          endcase
        end
        if (!rs && rnum == `HPR_REG_DATA && (wr || rd)) begin
          if (s_ff.mcr[`HPR_MCR_STEP]) begin
            nxt_s.adr[`HPR_ADDR_MSB:0] = s_ff.mcr[`HPR_MCR_DOWN] ? s_ff.adr[`HPR_ADDR_MSB:0] - `HPR_ADDR_STEP
              : s_ff.adr[`HPR_ADDR_MSB:0] + `HPR_ADDR_STEP;
          end
        end
      end
      HPR_WAIT: begin
        if (!wr && !rd) nxt_s.st = HPR_IDLE;
      end
      default: nxt_s.st = HPR_IDLE;
    endcase
    // Level request ends once the host drives select and register select low.
    if (cs && !rs && !s_ff.scr[`HPR_SCR_PMODE]) nxt_s.dreq = 1'b0;
    if (s_ff.pcnt != 6'h00) begin
      nxt_s.pcnt = s_ff.pcnt - 6'h01;
      if (s_ff.pcnt == 6'h01) nxt_s.dreq = 1'b0;
    end
    nxt_s.cpu_rd = 32'h0000_0000;
    if (cpu_sel) begin
      case (cpu_reg)
        `HPR_CPU_IDX: nxt_s.cpu_rd = {24'h00_0000, s_ff.idx};
        `HPR_CPU_GSR: nxt_s.cpu_rd = s_ff.gsr;
        `HPR_CPU_SCR: nxt_s.cpu_rd = s_ff.scr;
        `HPR_CPU_MCR: nxt_s.cpu_rd = s_ff.mcr;
        `HPR_CPU_IICR: nxt_s.cpu_rd = s_ff.iicr;
        `HPR_CPU_EICR: nxt_s.cpu_rd = s_ff.eicr;
        `HPR_CPU_ADR: nxt_s.cpu_rd = s_ff.adr;
        `HPR_CPU_DATA: nxt_s.cpu_rd = s_ff.data;
        `HPR_CPU_BCR: nxt_s.cpu_rd = s_ff.bcr;
        `HPR_CPU_DTR: nxt_s.cpu_rd = s_ff.dtr;
        `HPR_CPU_BICR: nxt_s.cpu_rd = s_ff.bicr;
        `HPR_CPU_RAM: nxt_s.cpu_rd = ram_crd;
        default: nxt_s.cpu_rd = 32'h0000_0000;
      endcase
      if (cpu_wr) begin
        case (cpu_reg)
          `HPR_CPU_GSR: nxt_s.gsr = cpu_wdata;
          `HPR_CPU_SCR: nxt_s.scr = cpu_wdata;
          `HPR_CPU_IICR: nxt_s.iicr[`HPR_IRQ_FLAG] = s_ff.iicr[`HPR_IRQ_FLAG] & cpu_wdata[`HPR_IRQ_FLAG];
          `HPR_CPU_EICR: nxt_s.eicr = cpu_wdata;
          `HPR_CPU_DATA: nxt_s.data = cpu_wdata;
          `HPR_CPU_DTR: begin
            if (cpu_wdata[`HPR_DTR_TRIG]) begin
              nxt_s.dtr[`HPR_DTR_TRIG] = 1'b1;
              nxt_s.dreq = 1'b1;
              if (s_ff.scr[`HPR_SCR_PMODE]) nxt_s.pcnt = `HPR_PULSE_CYCLES;
            end
          end
          `HPR_CPU_BICR: nxt_s.bicr[`HPR_BICR_STAT] = s_ff.bicr[`HPR_BICR_STAT] & cpu_wdata[`HPR_BICR_STAT];
          default: nxt_s.idx = s_ff.idx; // Read-only registers take no CPU write.
        endcase
      end
    end
    // A host hit on the last word sets the bank flag; set wins over the CPU clear.
    if (s_ff.st == HPR_ACT && !rs && rnum == `HPR_REG_DATA && s_ff.adr[`HPR_ADDR_MSB:2] == `HPR_LAST_WORD) begin
      nxt_s.bicr[`HPR_BICR_STAT] = 1'b1;
      nxt_s.iicr[`HPR_IRQ_FLAG] = 1'b1;
    end
    if (s_ff.st == HPR_ACT && !rs && wr && rnum == `HPR_REG_IICR) nxt_s.iicr[`HPR_IRQ_FLAG] = 1'b1;
    if (!nxt_s.dreq) nxt_s.dtr[`HPR_DTR_TRIG] = 1'b0;
    nxt_s.cirq = nxt_s.iicr[`HPR_IRQ_FLAG] | nxt_s.bicr[`HPR_BICR_STAT];
    nxt_s.boot = host_boot && !nxt_s.bcr[`HPR_BCR_HOST_OWNS];
    nxt_s.dpin = nxt_s.dreq ^ !nxt_s.scr[`HPR_SCR_POL];
  end
  // ****************************************
  // Registers and RAM
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '0;
      // With the polarity bit clear the request pin idles high, so it must leave reset high.
      s_ff.dpin <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end
  // RAM is left out of reset: clearing 2 kbytes of flops would cost far more than it buys.
  always_ff @(posedge mclk) begin
    if (s_ff.st == HPR_ACT && wr && !rs && rnum == `HPR_REG_DATA) ram_ff[h_word] <= hw;
    if (cpu_sel && cpu_wr && cpu_reg == `HPR_CPU_RAM) begin
      for (int b = 0; b < 4; b++) begin
        if (cpu_be[b]) ram_ff[c_word][8*b +: 8] <= cpu_wdata[8*b +: 8];
      end
    end
  end
  always_comb begin
    hp.host_rdata = s_ff.rd;
    hp.host_rdata_oe = s_ff.oe;
    hp.host_dma_request = s_ff.dpin;
    hp.host_irq = s_ff.eicr[`HPR_IRQ_FLAG];
    cpu_rdata = s_ff.cpu_rd;
    cpu_irq = s_ff.cirq;
    cpu_boot_from_ram = s_ff.boot;
    host_ram_owner = s_ff.bcr[`HPR_BCR_HOST_OWNS];
  end
endmodule : hpr_dev
`default_nettype wire

/* File: hdl/hpr_host.sv */
/*
 Holds the host end: turns user commands into index and data cycles on the pins.
 Assumes one command at a time; a command is held until done pulses.
*/
`include "hpr_map.svh"
`timescale 1ns/100ps
`default_nettype none
module hpr_host import hpr_pkg::*; #(parameter int HOLD = 4) (
  input wire logic mclk,
  input wire logic rst_b,
  hpr_if.host hp,
  input wire logic req,
  input wire logic req_wr,
  input wire logic req_status,
  input wire logic [5:0] req_reg,
  input wire logic [31:0] req_wdata,
  output logic done,
  output logic [31:0] rdata,
  output logic dma_req_seen,
  output logic irq_seen
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    hpr_st_t st;
    logic phase;
    logic [3:0] cnt;
    logic cs_n, rs, wr_n, rd_n, done;
    logic [31:0] wd, rd;
    logic dq, iq;
  } hpr_host_s_t;
  hpr_host_s_t s_ff, nxt_s;
  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    nxt_s.dq = hp.host_dma_request;
    nxt_s.iq = hp.host_irq;
    case (s_ff.st)
      HPR_IDLE: begin
        if (req) begin
          // Indexed access loads the index first, then strobes with select low.
          nxt_s.phase = !req_status;
          nxt_s.st = HPR_ACT;
          nxt_s.cnt = 4'(HOLD);
          nxt_s.cs_n = 1'b0;
          nxt_s.rs = 1'b1;
          nxt_s.wr_n = !(req_wr || !req_status);
          nxt_s.rd_n = !(!req_wr && req_status);
          nxt_s.wd = req_status ? req_wdata : {26'h000_0000, req_reg};
        end
      end
      HPR_ACT: begin
        nxt_s.cnt = s_ff.cnt - 4'h1;
        if (s_ff.cnt == 4'h0) begin
          if (!s_ff.rd_n) nxt_s.rd = hp.host_rdata;
          nxt_s.cs_n = 1'b1;
          nxt_s.wr_n = 1'b1;
          nxt_s.rd_n = 1'b1;
          nxt_s.cnt = 4'(HOLD);
          nxt_s.st = HPR_WAIT;
        end
      end
      HPR_WAIT: begin
        nxt_s.cnt = s_ff.cnt - 4'h1;
        if (s_ff.cnt == 4'h0) begin
          if (s_ff.phase) begin
            nxt_s.phase = 1'b0;
            nxt_s.st = HPR_ACT;
            nxt_s.cnt = 4'(HOLD);
            nxt_s.cs_n = 1'b0;
            nxt_s.rs = 1'b0;
            nxt_s.wr_n = !req_wr;
            nxt_s.rd_n = req_wr;
            nxt_s.wd = req_wdata;
          end else begin
            nxt_s.done = 1'b1;
            nxt_s.st = HPR_IDLE;
          end
        end
      end
      default: nxt_s.st = HPR_IDLE;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '{st: HPR_IDLE, phase: 1'b0, cnt: 4'h0, cs_n: 1'b1, rs: 1'b1, wr_n: 1'b1, rd_n: 1'b1,
        done: 1'b0, wd: 32'h0000_0000, rd: 32'h0000_0000, dq: 1'b0, iq: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end
  always_comb begin
    hp.host_select_n = s_ff.cs_n;
    hp.host_reg_select = s_ff.rs;
    hp.host_write_strobe_n = s_ff.wr_n;
    hp.host_read_strobe_n = s_ff.rd_n;
    hp.host_wdata = s_ff.wd;
    done = s_ff.done;
    rdata = s_ff.rd;
    dma_req_seen = s_ff.dq;
    irq_seen = s_ff.iq;
  end
endmodule : hpr_host
`default_nettype wire

/* File: verification/hpr_chk_asserts.sv */
/*
 Holds the pin-level checker of the host parallel RAM port.
 Assumes it sits beside the interface joining both ends, on the single mclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module hpr_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic host_select_n,
  input wire logic host_reg_select,
  input wire logic host_write_strobe_n,
  input wire logic host_read_strobe_n,
  input wire logic [31:0] host_wdata,
  input wire logic [31:0] host_rdata,
  input wire logic host_rdata_oe,
  input wire logic host_dma_request,
  input wire logic host_irq
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_oe_quiet;
    !host_rdata_oe ##1 !host_rdata_oe;
  endsequence
  sequence s_dma_hold;
    !host_dma_request [*8];
  endsequence
  property p_oe_cause;
    $rose(host_rdata_oe) |-> !$past(host_select_n, 2) && !$past(host_read_strobe_n, 2);
  endproperty
  property p_no_both;
    !(!host_write_strobe_n && !host_read_strobe_n);
  endproperty
  property p_strobe_cs;
    (!host_write_strobe_n || !host_read_strobe_n) |-> !host_select_n;
  endproperty
  property p_rs_hold;
    !host_select_n && !$past(host_select_n) |-> $stable(host_reg_select);
  endproperty
  property p_wd_hold;
    !host_write_strobe_n && !$past(host_write_strobe_n) |-> $stable(host_wdata);
  endproperty
  property p_oe_drop;
    $rose(host_select_n) |-> ##[1:6] !host_rdata_oe;
  endproperty
  // The synchroniser delay means no answer may appear right after the strobe.
  property p_sync;
    $fell(host_read_strobe_n) && !host_rdata_oe |=> s_oe_quiet;
  endproperty
  property p_dma_low;
    $fell(host_dma_request) |-> s_dma_hold;
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("read data enabled without a read");
  a_no_both: assert property (p_no_both) else $error("both strobes low");
  a_strobe_cs: assert property (p_strobe_cs) else $error("strobe without select");
  a_rs_hold: assert property (p_rs_hold) else $error("register select moved in a cycle");
  a_wd_hold: assert property (p_wd_hold) else $error("write data moved in a cycle");
  a_oe_drop: assert property (p_oe_drop) else $error("read data still driven after select");
  a_sync: assert property (p_sync) else $error("answer before synchronisation");
  a_dma_low: assert property (p_dma_low) else $error("request low too briefly");
endmodule : hpr_chk
`default_nettype wire

/* File: verification/tb_top.sv */
/*
 Holds the self-checking bench joining the device and host ends of the port.
 Assumes the design files and map header are compiled first; CPU side is driven here.
*/
`include "hpr_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import hpr_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic cpu_sel = 1'b0, cpu_wr = 1'b0, host_boot = 1'b0;
  logic [3:0] cpu_be = 4'hF, cpu_reg = 4'h0;
  logic [9:0] cpu_ram_addr = 10'h000;
  logic [31:0] cpu_wdata = 32'h0, cpu_rdata, cq;
  logic cpu_irq, cpu_boot_from_ram, host_ram_owner;
  logic req = 1'b0, req_wr = 1'b0, req_status = 1'b0;
  logic [5:0] req_reg = 6'h00;
  logic [31:0] req_wdata = 32'h0, rdata;
  logic done, dma_req_seen, irq_seen;
  int n_fail = 0;
  int samples_checked = 0;
  always #10 mclk = ~mclk;
  hpr_if u_hpr_if ();
  hpr_dev u_hpr_dev (.mclk(mclk), .rst_b(rst_b), .hp(u_hpr_if), .cpu_sel(cpu_sel), .cpu_wr(cpu_wr),
    .cpu_be(cpu_be), .cpu_reg(cpu_reg), .cpu_ram_addr(cpu_ram_addr), .cpu_wdata(cpu_wdata),
    .host_boot(host_boot), .cpu_rdata(cpu_rdata), .cpu_irq(cpu_irq), .cpu_boot_from_ram(cpu_boot_from_ram),
    .host_ram_owner(host_ram_owner));
  hpr_host u_hpr_host (.mclk(mclk), .rst_b(rst_b), .hp(u_hpr_if), .req(req), .req_wr(req_wr),
    .req_status(req_status), .req_reg(req_reg), .req_wdata(req_wdata), .done(done), .rdata(rdata),
    .dma_req_seen(dma_req_seen), .irq_seen(irq_seen));
  hpr_chk u_hpr_chk (.mclk(mclk), .rst_b(rst_b), .host_select_n(u_hpr_if.host_select_n),
    .host_reg_select(u_hpr_if.host_reg_select), .host_write_strobe_n(u_hpr_if.host_write_strobe_n),
    .host_read_strobe_n(u_hpr_if.host_read_strobe_n), .host_wdata(u_hpr_if.host_wdata),
    .host_rdata(u_hpr_if.host_rdata), .host_rdata_oe(u_hpr_if.host_rdata_oe),
    .host_dma_request(u_hpr_if.host_dma_request), .host_irq(u_hpr_if.host_irq));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic finish_test;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  // A command is held until done; req drops while done is high, before the idle host samples it again.
  task automatic hcmd(input logic wr, input logic st, input logic [5:0] r, input logic [31:0] d);
    int i;
    @(negedge mclk);
    req = 1'b1;
    req_wr = wr;
    req_status = st;
    req_reg = r;
    req_wdata = d;
    for (i = 0; i < 200 && done !== 1'b1; i++) @(negedge mclk);
    req = 1'b0;
    if (done !== 1'b1) chk("host done", 32'h1, 32'h0);
  endtask : hcmd
  task automatic cpu(input logic wr, input logic [3:0] r, input logic [9:0] a, input logic [31:0] d,
    input logic [3:0] be);
    @(negedge mclk);
    cpu_sel = 1'b1;
    cpu_wr = wr;
    cpu_reg = r;
    cpu_ram_addr = a;
    cpu_wdata = d;
    cpu_be = be;
    @(negedge mclk);
    cpu_sel = 1'b0;
    cq = cpu_rdata;
  endtask : cpu
  task automatic creg(input string nm, input logic [3:0] r, input logic [9:0] a, input logic [31:0] e);
    cpu(1'b0, r, a, 32'h0, 4'hF);
    chk(nm, e, cq);
  endtask : creg
  task automatic hrd(input string nm, input logic [5:0] r, input logic [31:0] e);
    hcmd(1'b0, 1'b0, r, 32'h0);
    chk(nm, e, rdata);
  endtask : hrd
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    creg("idx reset", `HPR_CPU_IDX, 10'h0, 32'h0);
    creg("scr reset", `HPR_CPU_SCR, 10'h0, 32'h0);
    chk("dma idle", 32'h1, {31'h0, u_hpr_if.host_dma_request});
    chk("boot idle", 32'h0, {31'h0, cpu_boot_from_ram});
  endtask : t_reset
  task automatic t_gsr;
    cpu(1'b1, `HPR_CPU_GSR, 10'h0, 32'h12345678, 4'hF);
    hcmd(1'b0, 1'b1, 6'h00, 32'h0);
    chk("gsr status read", 32'h12345678, rdata);
    hrd("gsr indexed read", `HPR_REG_GSR, 32'h12345678);
    hcmd(1'b1, 1'b0, `HPR_REG_GSR, 32'hCAFE0001);
    creg("gsr host write", `HPR_CPU_GSR, 10'h0, 32'hCAFE0001);
    hcmd(1'b1, 1'b1, `HPR_REG_ADR, {26'h0, `HPR_REG_ADR});
    cpu(1'b1, `HPR_CPU_IDX, 10'h0, 32'h0000003F, 4'hF);
    creg("idx host only", `HPR_CPU_IDX, 10'h0, {26'h0, `HPR_REG_ADR});
  endtask : t_gsr
  task automatic t_ro;
    cpu(1'b1, `HPR_CPU_MCR, 10'h0, 32'h3, 4'hF);
    cpu(1'b1, `HPR_CPU_ADR, 10'h0, 32'h100, 4'hF);
    cpu(1'b1, `HPR_CPU_BCR, 10'h0, 32'h1, 4'hF);
    creg("mcr read only", `HPR_CPU_MCR, 10'h0, 32'h0);
    creg("adr read only", `HPR_CPU_ADR, 10'h0, 32'h0);
    creg("bcr read only", `HPR_CPU_BCR, 10'h0, 32'h0);
  endtask : t_ro
  task automatic t_stream;
    int k;
    hcmd(1'b1, 1'b0, `HPR_REG_ADR, 32'h010);
    hcmd(1'b1, 1'b0, `HPR_REG_MCR, 32'h1);
    for (k = 1; k <= 3; k++) hcmd(1'b1, 1'b0, `HPR_REG_DATA, 32'h11111111 * k);
    creg("adr step up", `HPR_CPU_ADR, 10'h0, 32'h01C);
    for (k = 1; k <= 3; k++) creg("ram word", `HPR_CPU_RAM, 10'h00C + 10'h004 * k, 32'h11111111 * k);
    cpu(1'b1, `HPR_CPU_RAM, 10'h010, 32'h000000AA, 4'h1);
    creg("cpu byte write", `HPR_CPU_RAM, 10'h010, 32'h111111AA);
    hcmd(1'b1, 1'b0, `HPR_REG_ADR, 32'h018);
    hcmd(1'b1, 1'b0, `HPR_REG_MCR, 32'h3);
    hrd("host read down", `HPR_REG_DATA, 32'h33333333);
    hrd("host read next", `HPR_REG_DATA, 32'h22222222);
    creg("adr step down", `HPR_CPU_ADR, 10'h0, 32'h010);
  endtask : t_stream
  task automatic t_irq;
    int i;
    hcmd(1'b1, 1'b0, `HPR_REG_IICR, 32'h000000AB);
    chk("cpu irq set", 32'h1, {31'h0, cpu_irq});
    creg("iicr code", `HPR_CPU_IICR, 10'h0, 32'h000000AB);
    cpu(1'b1, `HPR_CPU_IICR, 10'h0, 32'h0, 4'hF);
    @(negedge mclk);
    chk("cpu irq clear", 32'h0, {31'h0, cpu_irq});
    cpu(1'b1, `HPR_CPU_EICR, 10'h0, 32'h000000FF, 4'hF);
    for (i = 0; i < 8 && irq_seen !== 1'b1; i++) @(negedge mclk);
    chk("host irq", 32'h1, {31'h0, irq_seen});
    hrd("eicr code", `HPR_REG_EICR, 32'h000000FF);
  endtask : t_irq
  task automatic t_last;
    hcmd(1'b1, 1'b0, `HPR_REG_MCR, 32'h0);
    hcmd(1'b1, 1'b0, `HPR_REG_ADR, 32'h3FC);
    hcmd(1'b1, 1'b0, `HPR_REG_DATA, 32'h5A5A5A5A);
    creg("bank flag", `HPR_CPU_BICR, 10'h0, 32'h1);
    creg("last word irq", `HPR_CPU_IICR, 10'h0, 32'h000000AB);
    cpu(1'b1, `HPR_CPU_BICR, 10'h0, 32'h0, 4'hF);
    cpu(1'b1, `HPR_CPU_BICR, 10'h0, 32'h1, 4'hF);
    creg("bank flag one ignored", `HPR_CPU_BICR, 10'h0, 32'h0);
  endtask : t_last
  // Counting low cycles at each falling edge measures the pulse width exactly.
  task automatic t_dma;
    int i;
    int lows;
    lows = 0;
    cpu(1'b1, `HPR_CPU_DTR, 10'h0, 32'h0, 4'hF);
    for (i = 0; i < 40; i++) @(negedge mclk) lows += (u_hpr_if.host_dma_request === 1'b0);
    chk("dtr zero ignored", 32'h0, lows);
    chk("dma seen idle", 32'h1, {31'h0, dma_req_seen});
    cpu(1'b1, `HPR_CPU_SCR, 10'h0, 32'h00000008, 4'hF);
    cpu(1'b1, `HPR_CPU_DTR, 10'h0, 32'h1, 4'hF);
    for (i = 0; i < 8 && u_hpr_if.host_dma_request !== 1'b0; i++) @(negedge mclk);
    for (i = 0; i < 100 && u_hpr_if.host_dma_request === 1'b0; i++) @(negedge mclk) lows++;
    chk("pulse width", {26'h0, `HPR_PULSE_CYCLES}, lows);
    chk("dma seen", 32'h0, {31'h0, dma_req_seen});
  endtask : t_dma
  task automatic t_owner;
    host_boot = 1'b1;
    @(negedge mclk);
    chk("boot from ram", 32'h1, {31'h0, cpu_boot_from_ram});
    hcmd(1'b1, 1'b0, `HPR_REG_BCR, 32'h1);
    creg("bcr host set", `HPR_CPU_BCR, 10'h0, 32'h1);
    chk("ram owner", 32'h1, {31'h0, host_ram_owner});
    chk("boot held by host", 32'h0, {31'h0, cpu_boot_from_ram});
  endtask : t_owner
  initial begin
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    t_reset();
    t_gsr();
    t_ro();
    t_stream();
    t_irq();
    t_last();
    t_dma();
    t_owner();
    finish_test();
  end
  initial begin
    #400000;
    n_fail++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
